// >>> hdl/wait_cs_regs.vh
`ifndef WAIT_CS_REGS_VH
`define WAIT_CS_REGS_VH

// ************************************************************
// I/O addresses of the indirect configuration ports.
// ************************************************************
`define IO_CFG_POINTER      8'hee
`define IO_CFG_DATA         8'hef

// ************************************************************
// Indirect register indices, selected through the pointer port.
// ************************************************************
`define IDX_WAIT_CTRL       8'h00
`define IDX_MEM_BOUNDARY    8'h01
`define IDX_REGION_BOUND    8'h02
`define IDX_REGION_ENABLE   8'h03

// ************************************************************
// Reset values.
// ************************************************************
`define RST_WAIT_CTRL       8'h00
`define RST_MEM_BOUNDARY    8'hf0
`define RST_REGION_BOUND    8'h0f
`define RST_REGION_ENABLE   8'h01
`define RST_POINTER         8'h00

// ************************************************************
// Wait control fields.
// ************************************************************
`define WC_MEM_HI           7
`define WC_MEM_LO           6
`define WC_OPCODE_BIT       5
`define WC_IO_HI            4
`define WC_IO_LO            3
`define WC_VECTOR_BIT       2
`define WC_DAISY_HI         1
`define WC_DAISY_LO         0

// ************************************************************
// Region enable fields.
// ************************************************************
`define RE_LOW_BIT          0
`define RE_HIGH_BIT         1

// ************************************************************
// Opcodes of the return-from-interrupt sequence.
// ************************************************************
`define OP_PREFIX           8'hed
`define OP_RETURN           8'h4d

// ************************************************************
// Extra wait counts after the prefix byte.
// ************************************************************
`define RETURN_FROM_INTERRUPT_EXTRA_SHORT    3'h1
`define RETURN_FROM_INTERRUPT_EXTRA_LONG     3'h3

`endif

// >>> hdl/wait_state_and_chip_select.v
`timescale 1ns/1ns
`include "wait_cs_regs.vh"

// Summary of operation
// RULE1 - Programmed waits first, then external wait sampled; code also samples it during acknowledge waits.
// RULE2 - Memory cycles get zero to three waits.
// RULE3 - Optional extra wait on opcode fetch cycles.
// RULE4 - Memory waits only inside programmed address range.
// RULE5 - External I/O cycles get 0,2,4,6 waits.
// RULE6 - On-chip I/O accesses never get waits.
// RULE7 - Optional one wait after acknowledge I/O strobe.
// RULE8 - Acknowledge gets 0,2,4,6 daisy settling waits.
// RULE9 - Return sequence gets 2 or 4 waits.
// RULE10 - Non-return opcode after prefix gets one wait.
// RULE11 - Four-bit boundaries compared with top address nibble.
// RULE12 - Low select when nibble at most low bound.
// RULE13 - High select between low and high bounds.
// RULE14 - Separate enables; low select enabled, bound F.
// RULE15 - High select disabled after power-up.
// RULE16 - Selects decode address only; glitches possible.
// RULE17 - Configuration through pointer and data ports.
// RULE18 - Evaluation mode drives wait pin with programmed waits.
// RULE19 - All wait counts cleared at reset.
// RULE20 - Internal wait ORed with external wait.
module wait_state_and_chip_select (
  input  wire        clk_sys,
  input  wire        resetn,
  input  wire [15:0] address,
  input  wire [7:0]  dataIn,
  input  wire        memRequestN,
  input  wire        io_request_strobe_n,
  input  wire        opcode_fetch_strobe_n,
  input  wire        readStrobeN,
  input  wire        writeStrobeN,
  input  wire        onChipIoHit,
  input  wire        evaluation_mode_pin,
  input  wire        waitPinIn,
  output reg  [7:0]  dataOut,
  output reg         dataOutEnable,
  output reg         coreWaitN,
  output reg         waitPinOut,
  output reg         waitPinOe,
  output reg         low_region_select_n,
  output reg         high_region_select_n
);

  // ************************************************************
  // Sequencer states.
  // ************************************************************
  localparam [2:0] ST_IDLE   = 3'h0;
  localparam [2:0] ST_M1     = 3'h1;
  localparam [2:0] ST_WAIT   = 3'h2;
  localparam [2:0] ST_RETURN_FROM_INTERRUPT   = 3'h3;
  localparam [2:0] ST_VECTOR = 3'h4;
  localparam [2:0] ST_HOLD   = 3'h5;

  reg [7:0] waitCtrl;
  reg [7:0] memBoundary;
  reg [7:0] region_boundary_reg;
  reg [7:0] regionEnable;
  reg [7:0] pointer;
  reg       evMode;
  reg       strapTaken;
  reg       prevMreqN;
  reg       prevIorqN;
  reg       prevM1N;
  reg       prevWrN;
  reg       prefixSeen;
  reg       fetchCycle;
  reg       ackCycle;
  reg       retiPending;
  reg [2:0] state;
  reg [2:0] count;
  reg [2:0] next_state;
  reg [2:0] next_count;
  reg       next_retiPending;
  reg       next_ackCycle;
  reg       next_fetchCycle;
  reg       next_programmedWait;
  reg       next_coreWaitN;
  reg [7:0] next_dataOut;

  wire [3:0] nibble     = address[15:12];                      // RULE11
  wire [1:0] memWaits   = waitCtrl[`WC_MEM_HI:`WC_MEM_LO];
  wire [1:0] ioCode     = waitCtrl[`WC_IO_HI:`WC_IO_LO];
  wire [1:0] daisyCode  = waitCtrl[`WC_DAISY_HI:`WC_DAISY_LO];
  wire       opcodeWait = waitCtrl[`WC_OPCODE_BIT];
  wire       vectorWait = waitCtrl[`WC_VECTOR_BIT];

  // Memory waits apply only between the two boundary nibbles.
  wire inMemRange = (nibble >= memBoundary[3:0]) &&
                    (nibble <= memBoundary[7:4]);              // RULE4

  wire memStart  = prevMreqN & ~memRequestN;
  wire ioStart   = prevIorqN & ~io_request_strobe_n;
  wire m1Start   = prevM1N & ~opcode_fetch_strobe_n;
  wire busIdle   = memRequestN & io_request_strobe_n &
                   opcode_fetch_strobe_n;

  // Extended daisy setting (4 or 6 waits) enables return stretching.
  wire retiExtended = daisyCode[1];

  // The wait pin is an input only outside evaluation mode.
  wire extWait = ~evMode & ~waitPinIn;

  // Config accesses are I/O cycles outside acknowledge.
  wire ioAccess  = ~io_request_strobe_n & opcode_fetch_strobe_n;
  wire hitPtr    = ioAccess && (address[7:0] == `IO_CFG_POINTER);
  wire hitData   = ioAccess && (address[7:0] == `IO_CFG_DATA);
  wire cfgWrite  = prevWrN & ~writeStrobeN;

  // Memory wait total for a plain memory access, at most three. The
  // opcode extra wait is added only in ST_M1, so a data access never
  // picks it up.
  wire [2:0] memCount = inMemRange ? {1'b0, memWaits} : 3'h0; // RULE2

  // ************************************************************
  // Strap capture and bus edge history.
  // ************************************************************

  // The evaluation strap is caught once, on the first edge after release,
  // so reset itself never loads a port value.
  always @(posedge clk_sys) begin
    if (!resetn) begin
      evMode     <= 1'b0;
      strapTaken <= 1'b0;
      prevMreqN  <= 1'b1;
      prevIorqN  <= 1'b1;
      prevM1N    <= 1'b1;
      prevWrN    <= 1'b1;
    end else begin
      if (!strapTaken) begin
        evMode     <= evaluation_mode_pin;                     // RULE18
        strapTaken <= 1'b1;
      end
      prevMreqN <= memRequestN;
      prevIorqN <= io_request_strobe_n;
      prevM1N   <= opcode_fetch_strobe_n;
      prevWrN   <= writeStrobeN;
    end
  end

  // ************************************************************
  // Configuration registers behind the pointer and data ports.
  // ************************************************************

  // Writes land on the falling write strobe, once per cycle.
  always @(posedge clk_sys) begin
    if (!resetn) begin
      waitCtrl            <= `RST_WAIT_CTRL;                   // RULE19
      memBoundary         <= `RST_MEM_BOUNDARY;
      region_boundary_reg <= `RST_REGION_BOUND;                // RULE14
      regionEnable        <= `RST_REGION_ENABLE;               // RULE15
      pointer             <= `RST_POINTER;
    end else if (cfgWrite && hitPtr) begin
      pointer <= dataIn;                                       // RULE17
    end else if (cfgWrite && hitData) begin
      case (pointer)                                           // RULE17
        `IDX_WAIT_CTRL:     waitCtrl            <= dataIn;
        `IDX_MEM_BOUNDARY:  memBoundary         <= dataIn;
        `IDX_REGION_BOUND:  region_boundary_reg <= dataIn;
        `IDX_REGION_ENABLE: regionEnable        <= {6'h00, dataIn[1:0]};
        default:            pointer             <= pointer;
      endcase
    end
  end

  // Read data for the two ports; unknown indices read as zero.
  always @* begin
    next_dataOut = 8'h00;
    if (hitPtr) begin
      next_dataOut = pointer;
    end else if (hitData) begin
      case (pointer)
        `IDX_WAIT_CTRL:     next_dataOut = waitCtrl;
        `IDX_MEM_BOUNDARY:  next_dataOut = memBoundary;
        `IDX_REGION_BOUND:  next_dataOut = region_boundary_reg;
        `IDX_REGION_ENABLE: next_dataOut = regionEnable;
        default:            next_dataOut = 8'h00;
      endcase
    end
  end

  // ************************************************************
  // Wait sequencer.
  // ************************************************************

  // An opcode fetch shows the fetch strobe one clock ahead of the memory
  // strobe, so ST_M1 waits one cycle to tell a fetch from an acknowledge.
  always @* begin
    next_state          = state;
    next_count          = count;
    next_retiPending    = retiPending;
    next_ackCycle       = ackCycle;
    next_fetchCycle     = fetchCycle;
    next_programmedWait = 1'b0;
    case (state)
      ST_IDLE: begin
        next_ackCycle   = 1'b0;
        next_fetchCycle = 1'b0;
        if (m1Start) begin
          next_state = ST_M1;
        end else if (memStart) begin
          next_count = memCount;
          next_state = (memCount == 3'h0) ? ST_HOLD : ST_WAIT;
        end else if (ioStart && opcode_fetch_strobe_n) begin
          if (onChipIoHit || ioCode == 2'h0) begin             // RULE6
            next_state = ST_HOLD;
          end else begin
            next_count = {ioCode, 1'b0};                       // RULE5
            next_state = ST_WAIT;
          end
        end
      end
      ST_M1: begin
        if (!memRequestN) begin
          next_fetchCycle  = 1'b1;
          next_retiPending = prefixSeen & retiExtended;
          next_count       = inMemRange ?
                             ({1'b0, memWaits} +
                              {2'b00, opcodeWait}) : 3'h0;     // RULE3
          if (next_count != 3'h0) begin
            next_state = ST_WAIT;
          end else if (next_retiPending) begin
            next_state = ST_RETURN_FROM_INTERRUPT;
          end else begin
            next_state = ST_HOLD;
          end
        end else begin
          next_ackCycle = 1'b1;
          next_count    = {daisyCode, 1'b0};                   // RULE8
          next_state    = (daisyCode == 2'h0) ? ST_VECTOR : ST_WAIT;
        end
      end
      ST_WAIT: begin
        next_programmedWait = 1'b1;
        next_count = count - 3'h1;
        if (count == 3'h1) begin
          if (retiPending) begin
            next_state = ST_RETURN_FROM_INTERRUPT;
          end else if (ackCycle && prevIorqN) begin
            next_state = ST_VECTOR;
          end else begin
            next_state = ST_HOLD;
          end
        end
      end
      ST_RETURN_FROM_INTERRUPT: begin
        // This cycle is itself the single wait after the prefix byte.
        next_programmedWait = 1'b1;                            // RULE10
        next_retiPending    = 1'b0;
        if (dataIn == `OP_RETURN) begin
          next_count = daisyCode[0] ? `RETURN_FROM_INTERRUPT_EXTRA_LONG :
                                      `RETURN_FROM_INTERRUPT_EXTRA_SHORT;       // RULE9
          next_state = ST_WAIT;
        end else begin
          next_state = ST_HOLD;
        end
      end
      ST_VECTOR: begin
        if (!io_request_strobe_n) begin
          if (vectorWait) begin                                // RULE7
            next_count = 3'h1;
            next_state = ST_WAIT;
          end else begin
            next_state = ST_HOLD;
          end
        end
      end
      ST_HOLD: begin
        if (busIdle) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // External wait joins only once programmed waits are done, except
  // during the acknowledge waits (daisy settling and vector wait), where both may overlap.
  always @* begin
    next_coreWaitN = ~(next_programmedWait |                   // RULE20
                       (extWait & (state == ST_HOLD)) |        // RULE1
                       (extWait & ackCycle & (state == ST_WAIT)));
  end

  // Sequencer registers and the prefix tracker. The prefix flag is taken
  // when a fetch ends, so the following fetch knows it follows the prefix.
  always @(posedge clk_sys) begin
    if (!resetn) begin
      state       <= ST_IDLE;
      count       <= 3'h0;
      retiPending <= 1'b0;
      ackCycle    <= 1'b0;
      fetchCycle  <= 1'b0;
      prefixSeen  <= 1'b0;
    end else begin
      state       <= next_state;
      count       <= next_count;
      retiPending <= next_retiPending;
      ackCycle    <= next_ackCycle;
      fetchCycle  <= next_fetchCycle;
      if (fetchCycle && memRequestN && !prevMreqN) begin
        prefixSeen <= (dataIn == `OP_PREFIX);                  // RULE9
      end
    end
  end

  // ************************************************************
  // Registered outputs.
  // ************************************************************

  // Region selects follow the address nibble alone, with no strobe
  // qualification; loads must tolerate short select pulses.
  always @(posedge clk_sys) begin
    if (!resetn) begin
      low_region_select_n  <= 1'b1;
      high_region_select_n <= 1'b1;
      coreWaitN            <= 1'b1;
      waitPinOut           <= 1'b1;
      waitPinOe            <= 1'b0;
      dataOut              <= 8'h00;
      dataOutEnable        <= 1'b0;
    end else begin
      low_region_select_n  <= ~(regionEnable[`RE_LOW_BIT] &&  // RULE16
                               (nibble <=
                                region_boundary_reg[3:0]));    // RULE12
      high_region_select_n <= ~(regionEnable[`RE_HIGH_BIT] &&
                               (nibble >
                                region_boundary_reg[3:0]) &&
                               (nibble <=
                                region_boundary_reg[7:4]));    // RULE13
      coreWaitN            <= next_coreWaitN;
      waitPinOut           <= ~next_programmedWait;            // RULE18
      waitPinOe            <= evMode;                          // RULE18
      dataOut              <= next_dataOut;
      dataOutEnable        <= (hitPtr | hitData) & ~readStrobeN;
    end
  end

endmodule // wait_state_and_chip_select

// >>> test/wait_cs_checker.sv
`timescale 1ns/1ns
// ****************************************
// Bus-cycle wait and region select checker
// ****************************************
module wait_cs_checker (
  input wire        clk_sys,
  input wire        resetn,
  input wire [15:0] address,
  input wire        memRequestN,
  input wire        io_request_strobe_n,
  input wire        opcode_fetch_strobe_n,
  input wire        readStrobeN,
  input wire        dataOutEnable,
  input wire        coreWaitN,
  input wire        waitPinOut,
  input wire        waitPinOe,
  input wire        low_region_select_n,
  input wire        high_region_select_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // Bus idle and configuration read decode.
  wire       idle = memRequestN & io_request_strobe_n & opcode_fetch_strobe_n;
  wire       cfgRead = ~io_request_strobe_n & ~readStrobeN &
                       opcode_fetch_strobe_n & (address[7:1] == 7'h77);
  reg  [3:0] lowRun;

  // Length of the current run of programmed waits; saturates at 15.
  always @(posedge clk_sys) begin
    if (!resetn || waitPinOut)
      lowRun <= 4'h0;
    else if (lowRun != 4'hf)
      lowRun <= lowRun + 4'h1;
  end

  reset_quiet_a: assert property (disable iff (1'b0) !resetn |=>
    coreWaitN && waitPinOut && !waitPinOe && !dataOutEnable &&
    low_region_select_n && high_region_select_n)
    else $error("outputs not quiet after reset");
  idle_nowait_a: assert property (idle && $past(idle) && $past(idle, 2)
    |-> coreWaitN && waitPinOut) else $error("wait while bus idle");
  strap_hold_a: assert property ($past(resetn) && $past(resetn, 2) &&
    $past(resetn, 3) |-> $stable(waitPinOe)) else $error("strap moved");
  read_cause_a: assert property (dataOutEnable |->
    $past(!io_request_strobe_n && !readStrobeN && address[7:1] == 7'h77))
    else $error("read data driven without port read");
  read_answer_a: assert property ($past(cfgRead && resetn) |->
    dataOutEnable) else $error("port read not answered");
  eval_pin_a: assert property (waitPinOe |-> coreWaitN == waitPinOut)
    else $error("external wait seen in evaluation mode");
  wait_or_a: assert property (!waitPinOut |-> !coreWaitN)
    else $error("programmed wait not passed to core");
  // A fetch of four waits, the check cycle and three return waits make
  // the longest legal run of eight.
  wait_bound_a: assert property (lowRun <= 4'h8)
    else $error("programmed wait run too long");
  select_excl_a: assert property (low_region_select_n ||
    high_region_select_n) else $error("both region selects active");
endmodule // wait_cs_checker

bind wait_state_and_chip_select wait_cs_checker chk (
  .clk_sys, .resetn, .address, .memRequestN, .io_request_strobe_n,
  .opcode_fetch_strobe_n, .readStrobeN, .dataOutEnable, .coreWaitN,
  .waitPinOut, .waitPinOe, .low_region_select_n, .high_region_select_n);

// >>> test/slow_memory_model.sv
`timescale 1ns/1ns
// ****************************************
// Slow external memory on the wait pin
// ****************************************
module slow_memory_model (
  input  wire       clk_sys,
  input  wire       memRequestN,
  input  wire [7:0] stall,
  output wire       waitPullN
);
  reg [7:0] held;

  // Cycles since select; saturates so a long access never wraps.
  always @(posedge clk_sys) begin
    if (memRequestN)
      held <= 8'h00;
    else if (held != 8'hff)
      held <= held + 8'h01;
  end

  // Open drain: only pulls low, released it shows the pull-up level.
  assign waitPullN = ~(~memRequestN && (held < stall));
endmodule // slow_memory_model

// >>> test/tb_top.sv
`timescale 1ns/1ns
// ****************************************
// Testbench for wait states and selects
// ****************************************
module tb_top;
  reg         clk_sys = 1'b0;
  reg         resetn = 1'b0;
  reg  [15:0] address = 16'h0000;
  reg  [7:0]  dataIn = 8'h00;
  reg         memRequestN = 1'b1;
  reg         ioN = 1'b1;
  reg         fetchN = 1'b1;
  reg         rdN = 1'b1;
  reg         wrN = 1'b1;
  reg         onChip = 1'b0;
  reg         evalPin = 1'b0;
  reg  [7:0]  stall = 8'h00;
  reg  [7:0]  waits;
  reg  [7:0]  want;
  wire [7:0]  dataOut;
  wire        pullN, waitOut, waitOe, coreWaitN, doutEn, lowN, highN;
  integer     n_errors = 0;
  integer     checks = 0;
  integer     cycles = 0;
  integer     i, j;

  // Wired-AND wait pin: the device drives it only in evaluation mode.
  wire waitWire = pullN & (waitOe ? waitOut : 1'b1);

  always #25 clk_sys = ~clk_sys;

  wait_state_and_chip_select DUT (.clk_sys(clk_sys), .resetn(resetn),
    .address(address), .dataIn(dataIn), .memRequestN(memRequestN),
    .io_request_strobe_n(ioN), .opcode_fetch_strobe_n(fetchN),
    .readStrobeN(rdN), .writeStrobeN(wrN), .onChipIoHit(onChip),
    .evaluation_mode_pin(evalPin), .waitPinIn(waitWire),
    .dataOut(dataOut), .dataOutEnable(doutEn), .coreWaitN(coreWaitN),
    .waitPinOut(waitOut), .waitPinOe(waitOe),
    .low_region_select_n(lowN), .high_region_select_n(highN));

  slow_memory_model mem (.clk_sys(clk_sys), .memRequestN(memRequestN),
    .stall(stall), .waitPullN(pullN));

  // Compare and count; four-state equality so unknowns never match.
  task check(input [7:0] seen, input [7:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask

  task wrap_up;
    begin
      $display("errors %0d of %0d checks", n_errors, checks);
      if (n_errors == 0 && checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  task drive(input mq, input iq, input fq, input [15:0] a, input [7:0] d);
    begin
      @(negedge clk_sys);
      memRequestN = mq;
      ioN = iq;
      fetchN = fq;
      address = a;
      dataIn = d;
    end
  endtask

  // Counts core wait cycles over a fixed window.
  task count(input integer k);
    repeat (k) begin
      @(negedge clk_sys);
      if (coreWaitN === 1'b0)
        waits = waits + 8'h01;
    end
  endtask

  // Release all strobes; new cycles need every strobe high first.
  task rest;
    begin
      @(negedge clk_sys);
      {memRequestN, ioN, fetchN, rdN, wrN} = 5'h1f;
      repeat (2) @(negedge clk_sys);
    end
  endtask

  task run(input mq, input iq, input fq, input [15:0] a, input [7:0] d);
    begin
      waits = 8'h00;
      drive(mq, iq, fq, a, d);
      count(12);
      rest;
    end
  endtask

  task ioWr(input [7:0] a, input [7:0] d);
    begin
      onChip = 1'b1;
      drive(1'b1, 1'b0, 1'b1, {8'h00, a}, d);
      @(negedge clk_sys);
      wrN = 1'b0;
      rest;
    end
  endtask

  task cfgWr(input [7:0] x, input [7:0] d);
    begin
      ioWr(8'hee, x);
      ioWr(8'hef, d);
    end
  endtask

  task cfgRd(input [7:0] x, input [7:0] e);
    begin
      ioWr(8'hee, x);
      drive(1'b1, 1'b0, 1'b1, 16'h00ef, 8'h00);
      rdN = 1'b0;
      repeat (2) @(negedge clk_sys);
      check(dataOut, e);
      check({7'h00, doutEn}, 8'h01);
      rest;
    end
  endtask

  task doReset;
    begin
      resetn = 1'b0;
      repeat (6) @(negedge clk_sys);
      resetn = 1'b1;
      rest;
    end
  endtask

  // A hang is cut short well beyond the roughly one thousand cycles needed.
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 8000) begin
      n_errors = n_errors + 1;
      wrap_up;
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    doReset;
    cfgRd(8'h00, 8'h00);
    cfgRd(8'h01, 8'hf0);
    cfgRd(8'h02, 8'h0f);
    cfgRd(8'h03, 8'h01);
    cfgRd(8'h07, 8'h00);
    drive(1'b1, 1'b1, 1'b1, 16'hf000, 8'h00);
    repeat (2) @(negedge clk_sys);
    check({6'h00, highN, lowN}, 8'h02);
    for (i = 0; i < 4; i = i + 1) begin
      cfgWr(8'h00, {i[1:0], 6'h00});
      run(1'b0, 1'b1, 1'b1, 16'h5000, 8'h00);
      check(waits, i[7:0]);
      cfgWr(8'h00, {i[1:0], 6'h20});
      run(1'b0, 1'b1, 1'b0, 16'h5000, 8'h00);
      check(waits, i[7:0] + 8'h01);
      run(1'b0, 1'b1, 1'b1, 16'h5000, 8'h00);
      check(waits, i[7:0]);
    end
    cfgWr(8'h01, 8'h31);
    cfgWr(8'h00, 8'hc0);
    run(1'b0, 1'b1, 1'b1, 16'h2000, 8'h00);
    check(waits, 8'h03);
    run(1'b0, 1'b1, 1'b1, 16'h8000, 8'h00);
    check(waits, 8'h00);
    cfgWr(8'h01, 8'hf0);
    for (i = 0; i < 4; i = i + 1) begin
      cfgWr(8'h00, {3'h0, i[1:0], 3'h0});
      onChip = 1'b0;
      run(1'b1, 1'b0, 1'b1, 16'h0040, 8'h00);
      check(waits, {i[6:0], 1'b0});
      onChip = 1'b1;
      run(1'b1, 1'b0, 1'b1, 16'h0040, 8'h00);
      check(waits, 8'h00);
      cfgWr(8'h00, {5'h00, i[0], i[1:0]});
      waits = 8'h00;
      drive(1'b1, 1'b1, 1'b0, 16'h0000, 8'h00);
      count(8);
      ioN = 1'b0;
      count(6);
      rest;
      check(waits, {i[6:0], 1'b0} + {7'h00, i[0]});
    end
    for (i = 1; i < 4; i = i + 1) begin
      for (j = 0; j < 2; j = j + 1) begin
        cfgWr(8'h00, {6'h00, i[1:0]});
        run(1'b0, 1'b1, 1'b0, 16'h0100, 8'hed);
        check(waits, 8'h00);
        run(1'b0, 1'b1, 1'b0, 16'h0101, j ? 8'h4d : 8'h00);
        want = (i < 2) ? 8'h00 : (j ? {i[6:0], 1'b0} - 8'h02 : 8'h01);
        check(waits, want);
      end
    end
    cfgWr(8'h02, 8'h73);
    cfgWr(8'h03, 8'h03);
    for (i = 0; i < 16; i = i + 1) begin
      drive(1'b1, 1'b1, 1'b1, {i[3:0], 12'h000}, 8'h00);
      repeat (2) @(negedge clk_sys);
      want = (i < 4) ? 8'h02 : ((i < 8) ? 8'h01 : 8'h03);
      check({6'h00, highN, lowN}, want);
    end
    cfgWr(8'h03, 8'h02);
    drive(1'b1, 1'b1, 1'b1, 16'h0000, 8'h00);
    repeat (2) @(negedge clk_sys);
    check({6'h00, highN, lowN}, 8'h03);
    cfgWr(8'h00, 8'h80);
    stall = 8'h06;
    run(1'b0, 1'b1, 1'b1, 16'h1000, 8'h00);
    stall = 8'h00;
    // The memory stalls through its first six edges and the core sees a
    // wait from the second edge after select, so five waits in all.
    check(waits, 8'h05);
    evalPin = 1'b1;
    doReset;
    check({7'h00, waitOe}, 8'h01);
    cfgWr(8'h00, 8'h40);
    stall = 8'h05;
    run(1'b0, 1'b1, 1'b1, 16'h1000, 8'h00);
    check(waits, 8'h01);
    wrap_up;
  end
endmodule // tb_top
